// *** rtl/pcfs_pkg.sv ***
// Constants, types and state layout for the program counter and fast stack.
// How it works
// - One shadow copy each of status, working and bank-select registers.
// - Software has no bus path to the shadow copies.
// - Interrupt vectoring copies status, working and bank into shadow.
// - Fast interrupt return reloads the three registers from shadow.
// - Low and high priority interrupts share the one shadow entry.
// - A nested high priority interrupt overwrites the shadow values.
// - Fast call saves the three registers; fast return restores them.
// - Program counter is 21 bits and holds a byte address.
// - Program counter low byte is a readable and writable register.
// - Counter bits 15 to 8 are not directly readable or writable.
// - Counter bits 20 to 16 are written from software only through the upper latch.
// - Counter bit zero is always zero for word alignment.
// - Sequential execution advances the counter by two.
// - Calls, jumps and branches load the counter, ignoring the latches.
// - Writing the low byte loads high and upper fields from latches.
// - Reading the low byte copies high and upper fields to latches.
// - Input clock divided by four into four phases per cycle.
// - Counter steps in phase one; instruction latched in phase four.
// - Fetched instruction executes in the next cycle, overlapping fetch.
package pcfs_pkg;

  localparam int PC_W = 21;

  localparam logic [7:0] ADDR_PCL    = 8'h00;
  localparam logic [7:0] ADDR_LATH   = 8'h04;
  localparam logic [7:0] ADDR_LATU   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_WORK   = 8'h10;
  localparam logic [7:0] ADDR_BANK   = 8'h14;
  localparam logic [7:0] ADDR_PHASE  = 8'h18;

  localparam logic [20:0] PC_RST   = 21'h000000;
  localparam logic [20:0] PC_STEP  = 21'h000002;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [4:0]  LATU_RST = 5'h00;
  localparam logic [15:0] IR_RST   = 16'h0000;

  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } pcfs_phase_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PCL,
    SEL_LATH,
    SEL_LATU,
    SEL_STATUS,
    SEL_WORK,
    SEL_BANK,
    SEL_PHASE
  } pcfs_sel_t;

  // Command from the instruction decoder, sampled in phase four.
  typedef struct packed {
    logic        vector;
    logic        fast_call;
    logic        fast_ret;
    logic        load;
    logic [20:0] target;
  } pcfs_cmd_t;

  typedef struct packed {
    logic [20:0] pc;
    logic [7:0]  lath;
    logic [4:0]  latu;
    logic [7:0]  status;
    logic [7:0]  work;
    logic [7:0]  bank;
    logic [7:0]  sh_status;
    logic [7:0]  sh_work;
    logic [7:0]  sh_bank;
    logic [15:0] ir;
    pcfs_phase_t phase;
    logic        skip_inc;
    logic        ack;
    logic [31:0] rdata;
  } pcfs_state_t;

endpackage

// *** rtl/pcfs_core.sv ***
// Program counter, latch registers, fast shadow stack and phase generator.
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
module pcfs_core
  import pcfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire pcfs_cmd_t   cmd,
  input  wire logic [15:0] instr_word,
  output logic      [20:0] fetch_addr,
  output logic      [15:0] instr_latched,
  output logic      [3:0]  phase_strobe,
  output logic      [7:0]  status_value,
  output logic      [7:0]  working_value,
  output logic      [7:0]  bank_value
);

  pcfs_state_t state_reg;
  pcfs_state_t state_next;
  logic        bus_take;
  logic        bus_wr;
  logic        pcl_wr;
  logic        pcl_rd;
  pcfs_sel_t   bus_sel;

  // Maps a byte address to a register; misaligned or unknown is none.
  function automatic pcfs_sel_t reg_decode(input logic [7:0] adr);
    pcfs_sel_t s;
    s = SEL_NONE;
    case (adr)
      ADDR_PCL:    s = SEL_PCL;
      ADDR_LATH:   s = SEL_LATH;
      ADDR_LATU:   s = SEL_LATU;
      ADDR_STATUS: s = SEL_STATUS;
      ADDR_WORK:   s = SEL_WORK;
      ADDR_BANK:   s = SEL_BANK;
      ADDR_PHASE:  s = SEL_PHASE;
      default:     s = SEL_NONE;
    endcase
    return s;
  endfunction

  // A request is taken in the cycle before ack rises, once per access.
  assign bus_take = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign bus_wr   = bus_take && wb_we_i && wb_sel_i[0];
  assign bus_sel  = reg_decode(wb_adr_i);
  assign pcl_wr   = bus_wr && (bus_sel == SEL_PCL);
  assign pcl_rd   = bus_take && !wb_we_i && (bus_sel == SEL_PCL);

  always_comb begin
    state_next     = state_reg;
    state_next.ack = bus_take;

    // The input clock is split into four phases per instruction cycle.
    case (state_reg.phase)
      PH_ONE:   state_next.phase = PH_TWO;
      PH_TWO:   state_next.phase = PH_THREE;
      PH_THREE: state_next.phase = PH_FOUR;
      PH_FOUR:  state_next.phase = PH_ONE;
      default:  state_next.phase = PH_ONE;
    endcase

    // A load in the previous phase four already points at the target,
    // so the following step is swallowed instead of skipping a word.
    if (state_reg.phase == PH_ONE) begin
      if (state_reg.skip_inc) begin
        state_next.skip_inc = 1'b0;
      end else begin
        state_next.pc = state_reg.pc + PC_STEP;
      end
    end

    if (state_reg.phase == PH_FOUR) begin
      // The decoder works on this word for the whole next cycle.
      state_next.ir = instr_word;
      if (cmd.vector || cmd.fast_call) begin
        // Either priority lands in the single entry, overwriting it.
        state_next.sh_status = state_reg.status;
        state_next.sh_work   = state_reg.work;
        state_next.sh_bank   = state_reg.bank;
      end else if (cmd.fast_ret) begin
        state_next.status = state_reg.sh_status;
        state_next.work   = state_reg.sh_work;
        state_next.bank   = state_reg.sh_bank;
      end
      // Plain calls and returns touch neither copy.
      if (cmd.load) begin
        // Direct loads bypass both latch registers.
        state_next.pc       = {cmd.target[20:1], 1'b0};
        state_next.skip_inc = 1'b1;
      end
    end

    // Bus accesses come last so that software writes win a collision.
    if (bus_wr) begin
      case (bus_sel)
        SEL_PCL: begin
          state_next.pc = {state_reg.latu, state_reg.lath,
                           wb_dat_i[7:1], 1'b0};
          state_next.skip_inc = 1'b1;
        end
        SEL_LATH:   state_next.lath   = wb_dat_i[7:0];
        SEL_LATU:   state_next.latu   = wb_dat_i[4:0];
        SEL_STATUS: state_next.status = wb_dat_i[7:0];
        SEL_WORK:   state_next.work   = wb_dat_i[7:0];
        SEL_BANK:   state_next.bank   = wb_dat_i[7:0];
        default:    state_next.rdata  = state_reg.rdata;
      endcase
    end

    if (bus_take && !wb_we_i) begin
      // The shadow copies have no address here.
      case (bus_sel)
        SEL_PCL: begin
          state_next.rdata = {24'h000000, state_reg.pc[7:0]};
          state_next.lath  = state_reg.pc[15:8];
          state_next.latu  = state_reg.pc[20:16];
        end
        SEL_LATH:   state_next.rdata = {24'h000000, state_reg.lath};
        SEL_LATU:   state_next.rdata = {27'h0000000, state_reg.latu};
        SEL_STATUS: state_next.rdata = {24'h000000, state_reg.status};
        SEL_WORK:   state_next.rdata = {24'h000000, state_reg.work};
        SEL_BANK:   state_next.rdata = {24'h000000, state_reg.bank};
        SEL_PHASE:  state_next.rdata = {30'h00000000, state_reg.phase};
        default:    state_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg.pc        <= PC_RST;
      state_reg.lath      <= BYTE_RST;
      state_reg.latu      <= LATU_RST;
      state_reg.status    <= BYTE_RST;
      state_reg.work      <= BYTE_RST;
      state_reg.bank      <= BYTE_RST;
      state_reg.sh_status <= BYTE_RST;
      state_reg.sh_work   <= BYTE_RST;
      state_reg.sh_bank   <= BYTE_RST;
      state_reg.ir        <= IR_RST;
      state_reg.phase     <= PH_ONE;
      state_reg.skip_inc  <= 1'b0;
      state_reg.ack       <= 1'b0;
      state_reg.rdata     <= 32'h00000000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o      = state_reg.rdata;
  assign wb_ack_o      = state_reg.ack;
  assign fetch_addr    = state_reg.pc;
  assign instr_latched = state_reg.ir;
  assign status_value  = state_reg.status;
  assign working_value = state_reg.work;
  assign bank_value    = state_reg.bank;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_phase
      assign phase_strobe[i] = (state_reg.phase == pcfs_phase_t'(i));
    end
  endgenerate

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_pc_aligned: assert property (
    state_reg.pc[0] == 1'b0)
    else $error("program counter lost word alignment");

  a_phase_ring: assert property (
    phase_strobe[0] |=> phase_strobe[1] ##1 phase_strobe[2]
      ##1 phase_strobe[3] ##1 phase_strobe[0])
    else $error("phase sequence broken");

  a_pc_step: assert property (
    (state_reg.phase == PH_ONE && !state_reg.skip_inc && !pcl_wr)
      |=> state_reg.pc == $past(state_reg.pc) + PC_STEP)
    else $error("program counter did not advance by two");

  a_pc_hold: assert property (
    (state_reg.phase == PH_TWO && !pcl_wr) |=> $stable(state_reg.pc))
    else $error("program counter moved outside phase one");

  a_ir_latch: assert property (
    (state_reg.phase == PH_FOUR)
      |=> instr_latched == $past(instr_word) ##1 $stable(instr_latched)
          ##1 $stable(instr_latched) ##1 $stable(instr_latched))
    else $error("instruction word not held for a full cycle");

  a_shadow_save: assert property (
    (state_reg.phase == PH_FOUR && (cmd.vector || cmd.fast_call))
      |=> state_reg.sh_status == $past(status_value)
          && state_reg.sh_work == $past(working_value)
          && state_reg.sh_bank == $past(bank_value))
    else $error("shadow stack not loaded on save");

  a_fast_restore: assert property (
    (state_reg.phase == PH_FOUR && cmd.fast_ret && !cmd.vector
      && !cmd.fast_call && !bus_wr)
      |=> status_value == $past(state_reg.sh_status)
          && working_value == $past(state_reg.sh_work)
          && bank_value == $past(state_reg.sh_bank))
    else $error("fast return did not restore registers");

  a_shadow_keep: assert property (
    !(state_reg.phase == PH_FOUR && (cmd.vector || cmd.fast_call))
      |=> $stable(state_reg.sh_status) && $stable(state_reg.sh_work)
          && $stable(state_reg.sh_bank))
    else $error("shadow stack changed without a save");

  a_jump_load: assert property (
    (state_reg.phase == PH_FOUR && cmd.load && !pcl_wr)
      |=> fetch_addr == {$past(cmd.target[20:1]), 1'b0}
          ##1 ($stable(fetch_addr) || $past(pcl_wr)))
    else $error("direct load not taken or stepped at once");

  a_pcl_write: assert property (
    pcl_wr |=> fetch_addr == {$past(state_reg.latu), $past(state_reg.lath),
                              $past(wb_dat_i[7:1]), 1'b0})
    else $error("low byte write did not merge the latches");

  a_pcl_read: assert property (
    pcl_rd |=> state_reg.lath == $past(fetch_addr[15:8])
               && state_reg.latu == $past(fetch_addr[20:16])
               && wb_dat_o[7:0] == $past(fetch_addr[7:0]))
    else $error("low byte read did not copy the upper fields");

  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Every taken request is answered in the very next cycle.
  a_ack_follow: assert property (
    bus_take |=> wb_ack_o)
    else $error("taken request not acknowledged");

  // No answer appears without a request behind it.
  a_ack_cause: assert property (
    !bus_take |=> !wb_ack_o)
    else $error("ack raised without a request");

  // Exactly one phase strobe is high in every cycle.
  a_phase_onehot: assert property (
    $onehot(phase_strobe))
    else $error("phase strobes not one-hot");

  // The counter also stays put across phase three.
  a_pc_hold_three: assert property (
    (state_reg.phase == PH_THREE && !pcl_wr) |=> $stable(state_reg.pc))
    else $error("program counter moved in phase three");

  // The instruction register only changes at the end of phase four.
  a_ir_only_four: assert property (
    (state_reg.phase != PH_FOUR) |=> $stable(instr_latched))
    else $error("instruction register changed outside phase four");

  // A direct load arms the skip of the following phase-one step.
  a_load_skip: assert property (
    (state_reg.phase == PH_FOUR && cmd.load) |=> state_reg.skip_inc)
    else $error("load did not suppress the next step");

  // Direct loads leave both latch registers as they were.
  a_latch_keep: assert property (
    (state_reg.phase == PH_FOUR && cmd.load && !bus_take)
      |=> $stable(state_reg.lath) && $stable(state_reg.latu))
    else $error("direct load disturbed the latch registers");

  // The high latch takes the low byte of a write.
  a_lath_write: assert property (
    (bus_wr && bus_sel == SEL_LATH)
      |=> state_reg.lath == $past(wb_dat_i[7:0]))
    else $error("high latch write lost");

  // The upper latch keeps only its five bits of a write.
  a_latu_write: assert property (
    (bus_wr && bus_sel == SEL_LATU)
      |=> state_reg.latu == $past(wb_dat_i[4:0]))
    else $error("upper latch write lost");

  // Addresses without a register read back as zero.
  a_unmapped_read: assert property (
    (bus_take && !wb_we_i && bus_sel == SEL_NONE) |=> wb_dat_o == '0)
    else $error("unmapped read returned data");

  // Outside phase four the decoder cannot touch the three registers.
  a_regs_quiet: assert property (
    (state_reg.phase != PH_FOUR && !bus_wr)
      |=> $stable(status_value) && $stable(working_value)
          && $stable(bank_value))
    else $error("registers changed without a command or write");

  // A save requested with a restore wins, so nothing is reloaded.
  a_save_wins: assert property (
    (state_reg.phase == PH_FOUR && cmd.fast_ret
      && (cmd.vector || cmd.fast_call) && !bus_wr)
      |=> $stable(status_value) && $stable(working_value)
          && $stable(bank_value))
    else $error("restore applied while a save was requested");

  // A plain command neither saves nor restores anything.
  a_plain_cmd: assert property (
    (state_reg.phase == PH_FOUR && !cmd.vector && !cmd.fast_call
      && !cmd.fast_ret && !bus_wr)
      |=> $stable(status_value) && $stable(working_value)
          && $stable(bank_value))
    else $error("plain command changed the registers");

  // A status write lands at the edge that takes the request.
  a_status_write: assert property (
    (bus_wr && bus_sel == SEL_STATUS)
      |=> status_value == $past(wb_dat_i[7:0]))
    else $error("status write lost");

  // A write with the low byte lane disabled leaves the registers.
  a_lane_off: assert property (
    (bus_take && wb_we_i && !wb_sel_i[0] && state_reg.phase != PH_FOUR)
      |=> $stable(status_value) && $stable(working_value)
          && $stable(bank_value))
    else $error("write with low lane off took effect");

  // Reads never disturb the three working registers.
  a_read_quiet: assert property (
    (bus_take && !wb_we_i && state_reg.phase != PH_FOUR)
      |=> $stable(status_value) && $stable(working_value)
          && $stable(bank_value))
    else $error("read changed a register");

endmodule

// *** tb/pcfs_dec_model.sv ***
// Instruction decoder stand-in that issues one command, in phase four, each time its issue task is called.
`timescale 1ns/1ns
module pcfs_dec_model
  import pcfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [3:0]  phase_strobe,
  input  wire logic [20:0] fetch_addr,
  output pcfs_cmd_t        cmd,
  output logic      [15:0] instr_word
);
  logic [20:0] last_pc;

  // Each program word is a scrambled copy of its own address.
  assign instr_word = fetch_addr[15:0] ^ 16'ha5c3;

  initial begin
    cmd = '0;
    last_pc = '0;
  end

  // The command stands through phase four only and is idle otherwise.
  task automatic issue(input pcfs_cmd_t c);
    do @(posedge clk); while (phase_strobe[2] !== 1'b1);
    cmd <= c;
    @(posedge clk);
    last_pc = fetch_addr;
    cmd <= '0;
  endtask
endmodule

// *** tb/pc_and_fast_context_stack_tb.sv ***
// Self-checking bench for the program counter and fast shadow stack.
`timescale 1ns/1ns
module pc_and_fast_context_stack_tb
  import pcfs_pkg::*;
;
  logic        clk, rst, cyc, stb, we, ack;
  logic [7:0]  adr, st, wk, bk;
  logic [3:0]  sel, ph, p;
  logic [31:0] wdat, rdat, r;
  logic [15:0] iw, il;
  logic [20:0] pc;
  pcfs_cmd_t   cmd;
  int          bad_count, cmp_count, cycles;

  pcfs_core dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmd(cmd), .instr_word(iw),
    .fetch_addr(pc), .instr_latched(il), .phase_strobe(ph),
    .status_value(st), .working_value(wk), .bank_value(bk));

  pcfs_dec_model dec_u (.clk(clk), .phase_strobe(ph), .fetch_addr(pc),
    .cmd(cmd), .instr_word(iw));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic set3(input logic [7:0] s, w, b);
    wr(ADDR_STATUS, s);
    wr(ADDR_WORK, w);
    wr(ADDR_BANK, b);
  endtask

  task automatic chk3(input logic [7:0] s, w, b);
    @(negedge clk);
    chk("status", {24'h0, s}, {24'h0, st});
    chk("working", {24'h0, w}, {24'h0, wk});
    chk("bank", {24'h0, b}, {24'h0, bk});
  endtask

  function automatic pcfs_cmd_t mk(input logic v, fc, fr,
                                   input logic [20:0] t);
    mk = '{v, fc, fr, 1'b1, t};
  endfunction

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up;
    end
  end

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pc", 32'h0, {11'h0, pc});
    for (int k = 0; k < 8; k++) begin
      p = ph;
      @(negedge clk);
      chk("phase", {28'h0, p[2:0], p[3]}, {28'h0, ph});
    end
    wr(ADDR_LATU, 8'h12);
    wr(ADDR_LATH, 8'h34);
    wr(ADDR_PCL, 8'h57);
    chk("pc", 32'h123456, {11'h0, pc});
    wr(ADDR_LATH, 8'haa);
    wr(ADDR_LATU, 8'h1f);
    bus(1'b0, ADDR_PCL, 32'h0, r);
    chk("pcl bit0", 32'h0, {31'h0, r[0]});
    bus(1'b0, ADDR_LATH, 32'h0, r);
    chk("high latch", 32'h34, r);
    bus(1'b0, ADDR_LATU, 32'h0, r);
    chk("upper latch", 32'h12, r);
    bus(1'b0, 8'h40, 32'h0, r);
    chk("unmapped", 32'h0, r);
    dec_u.issue(mk(1'b0, 1'b0, 1'b0, 21'h0abcd1));
    @(negedge clk);
    chk("pc", 32'h0abcd0, {11'h0, pc});
    chk("instr", {16'h0, dec_u.last_pc[15:0] ^ 16'ha5c3},
        {16'h0, il});
    repeat (4) @(negedge clk);
    chk("pc", 32'h0abcd0, {11'h0, pc});
    @(negedge clk);
    chk("pc", 32'h0abcd2, {11'h0, pc});
    bus(1'b0, ADDR_LATH, 32'h0, r);
    chk("high latch", 32'h34, r);
    set3(8'h11, 8'h22, 8'h33);
    dec_u.issue(mk(1'b1, 1'b0, 1'b0, 21'h000100));
    set3(8'h44, 8'h55, 8'h66);
    dec_u.issue(mk(1'b1, 1'b0, 1'b0, 21'h000200));
    set3(8'h77, 8'h88, 8'h99);
    dec_u.issue(mk(1'b0, 1'b0, 1'b0, 21'h000300));
    chk3(8'h77, 8'h88, 8'h99);
    dec_u.issue(mk(1'b0, 1'b0, 1'b1, 21'h000400));
    chk3(8'h44, 8'h55, 8'h66);
    set3(8'ha1, 8'ha2, 8'ha3);
    dec_u.issue(mk(1'b0, 1'b1, 1'b0, 21'h000500));
    set3(8'hb1, 8'hb2, 8'hb3);
    dec_u.issue(mk(1'b0, 1'b0, 1'b0, 21'h000600));
    dec_u.issue(mk(1'b0, 1'b0, 1'b1, 21'h000700));
    chk3(8'ha1, 8'ha2, 8'ha3);
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk("status rd", 32'ha1, r);
    bus(1'b0, ADDR_PHASE, 32'h0, r);
    // The phase seen now is one past the phase of the taking edge.
    chk("phase rd", {28'h0, 4'h1 << (r[1:0] + 2'd1)}, {28'h0, ph});
    wrap_up;
  end
endmodule
